// ---- core/plcrc_top.sv ----
// APB register bank for divider reset and charge pump float of both loops
// Assumes synchronous APB master on pclk and a synchronous chip enable pin
`timescale 1ns/1ps
`default_nettype none
`include "plcrc_consts.svh"
module plcrc_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PLCRC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic chip_enable,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic main_loop_divider_reset,
  output logic main_pump_float,
  output logic aux_loop_divider_reset,
  output logic aux_pump_float,
  output logic powered
);
  plcrc_pkg::plcrc_ctrl_t ctrl_r;
  plcrc_pkg::plcrc_ctrl_t ctrl_nxt;
  logic pwr_sw_r;
  logic pwr_sw_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic powered_r;
  logic powered_nxt;
  logic [3:0] pwrup_cnt_r;
  logic [3:0] pwrup_cnt_nxt;
  logic pwrup_rst;
  logic setup;
  logic access;
  logic hit;
  plcrc_pkg::plcrc_loop_t main_loop;
  plcrc_pkg::plcrc_loop_t aux_loop;

  // No wait state: pready rises in the first access cycle
  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign hit = (paddr == `PLCRC_CTRL_OFFSET) || (paddr == `PLCRC_STAT_OFFSET) ||
    (paddr == `PLCRC_PWR_OFFSET);
  assign pwrup_rst = (pwrup_cnt_r != 4'h0);

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    pwr_sw_nxt = pwr_sw_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = !hit;
      prdata_nxt = 32'h0;
      if (!pwrite)
      begin
        case (paddr)
          `PLCRC_CTRL_OFFSET: prdata_nxt = {28'h0, ctrl_r};
          `PLCRC_STAT_OFFSET: prdata_nxt = {26'h0, powered_r, pwrup_rst,
            aux_loop, main_loop};
          `PLCRC_PWR_OFFSET: prdata_nxt = {31'h0, pwr_sw_r};
          default: prdata_nxt = 32'h0;
        endcase
      end
    end
    if (access && pwrite && pstrb[0])
    begin
      case (paddr)
        `PLCRC_CTRL_OFFSET: ctrl_nxt = pwdata[3:0];
        `PLCRC_PWR_OFFSET: pwr_sw_nxt = pwdata[`PLCRC_BIT_PWR_SW];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_comb
  begin
    powered_nxt = pwr_sw_r && chip_enable;
    pwrup_cnt_nxt = pwrup_cnt_r;
    // Rising power from either source restarts the divider reset
    if (powered_nxt && !powered_r)
    begin
      pwrup_cnt_nxt = `PLCRC_PWRUP_CYCLES;
    end
    else if (pwrup_cnt_r != 4'h0)
    begin
      pwrup_cnt_nxt = pwrup_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `PLCRC_CTRL_RESET;
      pwr_sw_r <= `PLCRC_PWR_RESET;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      powered_r <= 1'b0;
      pwrup_cnt_r <= 4'h0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      pwr_sw_r <= pwr_sw_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      powered_r <= powered_nxt;
      pwrup_cnt_r <= pwrup_cnt_nxt;
    end
  end

  plcrc_loop_gate u_main
  (
    .pclk(pclk),
    .presetn(presetn),
    .rst_bit(ctrl_r.main_rst),
    .float_bit(ctrl_r.main_float),
    .pwrup_rst(pwrup_rst),
    .loop_o(main_loop)
  );

  plcrc_loop_gate u_aux
  (
    .pclk(pclk),
    .presetn(presetn),
    .rst_bit(ctrl_r.aux_rst),
    .float_bit(ctrl_r.aux_float),
    .pwrup_rst(pwrup_rst),
    .loop_o(aux_loop)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign main_loop_divider_reset = main_loop.divider_reset;
  assign main_pump_float = main_loop.pump_hiz;
  assign aux_loop_divider_reset = aux_loop.divider_reset;
  assign aux_pump_float = aux_loop.pump_hiz;
  assign powered = powered_r;

  // Loop outputs pass one more flop, so they answer one edge after the control state
  AST_MAIN_RST: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r.main_rst |=>
    main_loop_divider_reset && main_pump_float)
    else $error("Main reset bit not honoured");

  AST_AUX_RST: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r.aux_rst |=>
    aux_loop_divider_reset && aux_pump_float)
    else $error("Aux reset bit not honoured");

  AST_PWRUP: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(powered_r) |=>
    main_loop_divider_reset [*4])
    else $error("Power-up divider reset missing");

  AST_PWRUP_AUX: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(powered_r) |=>
    aux_loop_divider_reset [*4])
    else $error("Power-up aux divider reset missing");

  AST_PWRUP_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(powered_r) |=>
    (main_pump_float && aux_pump_float) [*4])
    else $error("Pumps drove during power-up reset");

  AST_PWRUP_END: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(powered_r) ##1 (powered_r && ctrl_r == 4'h0) [*6] |->
    !main_loop_divider_reset)
    else $error("Power-up reset did not end");

  // A power-down must never start a divider reset on its own
  AST_NO_SPURIOUS_PWRUP: assert property (@(posedge pclk) disable iff (!presetn)
    (pwrup_cnt_r == 4'h0 && (powered_r || !(pwr_sw_r && chip_enable))) |=>
    !pwrup_rst)
    else $error("Power-up reset without a power-up");

  AST_PWRUP_CNT_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    pwrup_cnt_r <= `PLCRC_PWRUP_CYCLES)
    else $error("Power-up counter out of range");

  AST_POWERED_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr_sw_r && chip_enable) |=>
    powered)
    else $error("Powered flag missing");

  AST_POWERED_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !(pwr_sw_r && chip_enable) |=>
    !powered)
    else $error("Powered flag stuck");

  AST_MAIN_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.main_float && !ctrl_r.main_rst && !pwrup_rst) |=>
    main_pump_float && !main_loop_divider_reset)
    else $error("Main float bit wrong");

  AST_AUX_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.aux_float && !ctrl_r.aux_rst && !pwrup_rst) |=>
    aux_pump_float && !aux_loop_divider_reset)
    else $error("Aux float bit wrong");

  AST_MAIN_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_r.main_rst && !ctrl_r.main_float && !pwrup_rst) |=>
    !main_loop_divider_reset && !main_pump_float)
    else $error("Main loop not in normal operation");

  AST_AUX_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_r.aux_rst && !ctrl_r.aux_float && !pwrup_rst) |=>
    !aux_loop_divider_reset && !aux_pump_float)
    else $error("Aux loop not in normal operation");

  AST_DEFAULTS: assert property (@(posedge pclk)
    !presetn |=>
    ctrl_r == 4'h0)
    else $error("Control bits not clear after reset");

  AST_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.main_rst && ctrl_r.main_float) |=>
    main_loop == 2'h3)
    else $error("Combined main reset and float wrong");

  AST_AUX_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.aux_rst && ctrl_r.aux_float) |=>
    aux_loop == 2'h3)
    else $error("Combined aux reset and float wrong");

  AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=>
    pready)
    else $error("Slave did not answer in one cycle");

  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=>
    !pready)
    else $error("Ready held longer than one cycle");

  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |->
    pready)
    else $error("Error flag without ready");

  AST_MAPPED_OK: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit) |=>
    !pslverr)
    else $error("Error on a mapped address");

  AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit) |=>
    pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused");

  AST_UNMAPPED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && !hit) |=>
    $stable(ctrl_r) && $stable(pwr_sw_r))
    else $error("Unmapped write changed a register");

  AST_NOSTRB_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && !pstrb[0]) |=>
    $stable(ctrl_r) && $stable(pwr_sw_r))
    else $error("Write without low strobe changed a register");

  AST_CTRL_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == `PLCRC_CTRL_OFFSET) |=>
    prdata == {28'h0, $past(ctrl_r)})
    else $error("Control read data wrong");

  AST_STAT_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == `PLCRC_STAT_OFFSET) |=>
    prdata == {26'h0, $past(powered_r), $past(pwrup_rst), $past(aux_loop), $past(main_loop)})
    else $error("Status read data wrong");

  AST_PWR_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == `PLCRC_PWR_OFFSET) |=>
    prdata == {31'h0, $past(pwr_sw_r)})
    else $error("Power read data wrong");

  COV_MAIN_RST: cover property (@(posedge pclk) disable iff (!presetn)
    main_loop_divider_reset && powered);

  COV_AUX_FLOAT: cover property (@(posedge pclk) disable iff (!presetn)
    aux_pump_float && !aux_loop_divider_reset);

  COV_PWRUP: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(powered_r));

  COV_ERR: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr && pready);

  COV_MAIN_BOTH: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl_r.main_rst && ctrl_r.main_float);
endmodule : plcrc_top
`default_nettype wire

// ---- core/plcrc_consts.svh ----
// Constants for the loop divider reset and charge pump float control block
// Assumes inclusion by core and testbench files; definitions only
`ifndef PLCRC_CONSTS_SVH
`define PLCRC_CONSTS_SVH

`define PLCRC_CTRL_OFFSET 12'h000
`define PLCRC_STAT_OFFSET 12'h004
`define PLCRC_PWR_OFFSET 12'h008
`define PLCRC_ADDR_W 12

`define PLCRC_BIT_AUX_RST 0
`define PLCRC_BIT_MAIN_RST 1
`define PLCRC_BIT_MAIN_FLOAT 2
`define PLCRC_BIT_AUX_FLOAT 3
`define PLCRC_BIT_PWR_SW 0

`define PLCRC_CTRL_RESET 4'h0
`define PLCRC_PWR_RESET 1'b0
`define PLCRC_PWRUP_CYCLES 4'h4

`endif

// ---- core/plcrc_pkg.sv ----
// Types for the loop divider reset and charge pump float control block
// Assumes the constants header is compiled alongside
package plcrc_pkg;
  typedef struct packed {
    logic aux_float;
    logic main_float;
    logic main_rst;
    logic aux_rst;
  } plcrc_ctrl_t;

  typedef struct packed {
    logic divider_reset;
    logic pump_hiz;
  } plcrc_loop_t;
endpackage : plcrc_pkg

// ---- core/plcrc_loop_gate.sv ----
// Per-loop gate: divider reset and charge pump float outputs of one loop
// Assumes synchronous control levels on pclk
`timescale 1ns/1ps
`default_nettype none
module plcrc_loop_gate
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rst_bit,
  input wire logic float_bit,
  input wire logic pwrup_rst,
  output var plcrc_pkg::plcrc_loop_t loop_o
);
  plcrc_pkg::plcrc_loop_t loop_r;
  plcrc_pkg::plcrc_loop_t loop_nxt;

  always_comb
  begin
    // Reset bit dominates, float never releases a held divider
    loop_nxt.divider_reset = rst_bit | pwrup_rst;
    loop_nxt.pump_hiz = rst_bit | float_bit | pwrup_rst;
  end

  // Outputs come out of reset held so the pumps never drive uncontrolled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_r <= 2'h3;
    end
    else
    begin
      loop_r <= loop_nxt;
    end
  end

  assign loop_o = loop_r;

  AST_RST_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    rst_bit |=> loop_r.divider_reset && loop_r.pump_hiz)
    else $error("Reset bit did not hold divider and float pump");
  AST_FLOAT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (float_bit && !rst_bit && !pwrup_rst) |=> loop_r.pump_hiz && !loop_r.divider_reset)
    else $error("Float bit disturbed dividers or pump still drives");
  AST_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
    (!float_bit && !rst_bit && !pwrup_rst) |=> loop_r == 2'h0)
    else $error("Loop not in normal operation with all bits clear");
endmodule : plcrc_loop_gate
`default_nettype wire

// ---- testbench/plcrc_top_tb_top.sv ----
// Self-checking bench for the divider reset and pump float register bank
// Assumes the design package and constants header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "plcrc_consts.svh"
module plcrc_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic chip_enable = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, powered;
  wire logic mrst, mflt, arst, aflt;
  wire logic [31:0] outs = {28'h0, arst, aflt, mrst, mflt};
  int miscompares = 0;
  int compares = 0;
  int cnt;
  logic [31:0] rd;
  logic err;
  logic [3:0] cur, nv, s;

  always #10 pclk = ~pclk;

  plcrc_top dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .chip_enable(chip_enable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_loop_divider_reset(mrst), .main_pump_float(mflt),
    .aux_loop_divider_reset(arst), .aux_pump_float(aflt), .powered(powered)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Reset bit wins over float bit, so a reset also floats the pump
  function automatic logic [31:0] stat_exp(input logic [3:0] c);
    logic m, a;
    m = c[`PLCRC_BIT_MAIN_RST];
    a = c[`PLCRC_BIT_AUX_RST];
    return {28'h0, a, a | c[`PLCRC_BIT_AUX_FLOAT], m, m | c[`PLCRC_BIT_MAIN_FLOAT]};
  endfunction : stat_exp

  // Request stands until the rising edge that samples pready high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse_count(output int c);
    c = 0;
    repeat (12)
    begin
      @(negedge pclk);
      if (outs === 32'hf) c++;
    end
  endtask : pulse_count

  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (4000) @(posedge pclk);
    miscompares++;
    final_report;
  end

  initial
  begin
    void'($urandom(32'hfb13));
    @(negedge pclk);
    check("held_in_reset", outs, 32'hf);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("after_reset", outs, 32'h0);
    apb(1'b0, `PLCRC_CTRL_OFFSET, 32'h0, 4'h0);
    check("ctrl_default", rd, 32'h0);
    cur = 4'h0;
    // Every combination once, then random values with random strobes
    for (int i = 0; i < 28; i++)
    begin
      nv = (i < 16) ? i[3:0] : 4'($urandom);
      s = 4'($urandom) | {3'b0, i < 16};
      apb(1'b1, `PLCRC_CTRL_OFFSET, {$urandom} & 32'hfffffff0 | {28'h0, nv}, s);
      if (s[0]) cur = nv;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check("loop_outputs", outs, stat_exp(cur));
      apb(1'b0, `PLCRC_STAT_OFFSET, 32'h0, 4'h0);
      check("status", rd, stat_exp(cur));
      apb(1'b0, `PLCRC_CTRL_OFFSET, 32'h0, 4'h0);
      check("ctrl_readback", rd, {28'h0, cur});
    end
    apb(1'b1, 12'h00c, 32'hf, 4'hf);
    check("unmapped_write_err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h00c, 32'h0, 4'h0);
    check("unmapped_read_err", {31'h0, err}, 32'h1);
    check("unmapped_read_data", rd, 32'h0);
    check("unmapped_no_effect", outs, stat_exp(cur));
    apb(1'b1, `PLCRC_CTRL_OFFSET, 32'h0, 4'hf);
    chip_enable <= 1'b1;
    apb(1'b1, `PLCRC_PWR_OFFSET, 32'h1, 4'hf);
    pulse_count(cnt);
    check("sw_powerup_len", 32'(cnt), 32'(`PLCRC_PWRUP_CYCLES));
    check("powered", {31'h0, powered}, 32'h1);
    apb(1'b0, `PLCRC_STAT_OFFSET, 32'h0, 4'h0);
    check("status_powered", rd, 32'h20);
    apb(1'b0, `PLCRC_PWR_OFFSET, 32'h0, 4'h0);
    check("pwr_readback", rd, 32'h1);
    @(posedge pclk);
    chip_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check("powered_down", {31'h0, powered}, 32'h0);
    check("no_pulse_down", outs, 32'h0);
    @(posedge pclk);
    chip_enable <= 1'b1;
    pulse_count(cnt);
    check("pin_powerup_len", 32'(cnt), 32'(`PLCRC_PWRUP_CYCLES));
    final_report;
  end
endmodule : plcrc_top_tb_top
`default_nettype wire
